// ### logic/sar_port_pkg.sv
// Shared constants for the converter read port and its host controller
package sar_port_pkg;
  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int RESULT_W = 16;
  localparam int HALF_W = 8;
  localparam int CONV_EDGES = 16;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACQ_TIME_NS = 400;
  localparam int START_LOW_NS = 20;
  localparam int ACQ_CYCLES =
    (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_CYCLES =
    (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_WAIT_CYCLES = 8;
  localparam int CONV_HALF_DEFAULT = 2;
  localparam int FIFO_DEPTH_DEFAULT = 8;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [4:0] EDGE_COUNT_RESET = 5'h00;
endpackage

// ### logic/sar_link_if.sv
// Pin-level link between the converter port and its host controller
`timescale 1ns/1ps
interface sar_link_if;
  logic conv_clk;
  logic conversion_start_n;
  logic cs_n;
  logic rd_n;
  logic byte_sel;
  logic busy;
  logic [15:0] result_bus_out;
  logic result_bus_oe;
  wire [15:0] result_bus;

  // ---------------------------------------------------------------
  // Bus resolution
  // ---------------------------------------------------------------
  // Pads float when released; the inverse exposes a read of a dead bus
  assign result_bus = result_bus_oe ? result_bus_out : ~result_bus_out;

  modport device (
    input conv_clk,
    input conversion_start_n,
    input cs_n,
    input rd_n,
    input byte_sel,
    output busy,
    output result_bus_out,
    output result_bus_oe
  );

  modport host (
    output conv_clk,
    output conversion_start_n,
    output cs_n,
    output rd_n,
    output byte_sel,
    input busy,
    input result_bus
  );
endinterface

// ### logic/sar_device.sv
// Converter end: conversion sequencing, result hold and read port
`timescale 1ns/1ps
module sar_device (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  sar_link_if.device link,
  input wire logic [sar_port_pkg::RESULT_W-1:0] analog_sample_i,
  output logic [sar_port_pkg::RESULT_W-1:0] last_result_o
);
  import sar_port_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic conv_clk_prev;
  logic start_n_prev;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pin_s1 <= 5'h1F;
      pin_s2 <= 5'h1F;
      conv_clk_prev <= 1'b1;
      start_n_prev <= 1'b1;
    end else if (ce_i) begin
      pin_s1 <= {link.conv_clk, link.conversion_start_n, link.cs_n,
                 link.rd_n, link.byte_sel};
      pin_s2 <= pin_s1;
      conv_clk_prev <= pin_s2[4];
      start_n_prev <= pin_s2[3];
    end
  end

  logic conv_rise;
  logic start_fall;
  // A start with chip select high is not a conversion
  assign conv_rise = pin_s2[4] & ~conv_clk_prev;
  assign start_fall = start_n_prev & ~pin_s2[3] & ~pin_s2[2];

  // ---------------------------------------------------------------
  // Conversion sequencing
  // ---------------------------------------------------------------
  logic busy;
  logic [4:0] edge_count;
  logic [RESULT_W-1:0] held;
  logic [RESULT_W-1:0] approx;
  logic [RESULT_W-1:0] result;
  logic [RESULT_W-1:0] trial;
  logic [3:0] bit_idx;

  assign bit_idx = 4'(CONV_EDGES - 1) - edge_count[3:0];
  assign trial = approx | (RESULT_W'(1) << bit_idx);

  // Clock may stop between conversions; nothing here counts idle edges
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      busy <= 1'b0;
      edge_count <= EDGE_COUNT_RESET;
    end else if (ce_i) begin
      if (!busy && start_fall) begin
        busy <= 1'b1;
        edge_count <= EDGE_COUNT_RESET;
      end else if (busy && conv_rise) begin
        if (edge_count == 5'(CONV_EDGES - 1)) begin
          busy <= 1'b0;
        end
        edge_count <= edge_count + 5'h01;
      end
    end
  end

  // Sample is taken only at the start edge
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      held <= RESULT_RESET;
    end else if (ce_i && !busy && start_fall) begin
      held <= analog_sample_i;
    end
  end

  // One bit decided per conversion clock edge, msb first
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      approx <= RESULT_RESET;
    end else if (ce_i) begin
      if (!busy && start_fall) begin
        approx <= RESULT_RESET;
      end else if (busy && conv_rise && trial <= held) begin
        approx <= trial;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      result <= RESULT_RESET;
    end else if (ce_i && busy && conv_rise &&
                 edge_count == 5'(CONV_EDGES - 1)) begin
      result <= (trial <= held) ? trial : approx;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [RESULT_W-1:0] bus_out;
  logic bus_oe;

  // Byte select is resampled every cycle, so no new read edge is needed
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      bus_out <= RESULT_RESET;
      bus_oe <= 1'b0;
    end else if (ce_i) begin
      bus_oe <= ~pin_s2[2] & ~pin_s2[1];
      if (pin_s2[0]) begin
        bus_out <= {{HALF_W{1'b0}}, result[RESULT_W-1:HALF_W]};
      end else begin
        bus_out <= result;
      end
    end
  end

  assign link.busy = busy;
  assign link.result_bus_out = bus_out;
  assign link.result_bus_oe = bus_oe;
  assign last_result_o = result;
endmodule

// ### logic/sar_host.sv
// Host end: conversion clock, start and read sequencing, result FIFO
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end
endmodule

module sar_host #(
  parameter bit BYTE_MODE = 1'b0,
  parameter bit GATED_CLOCK = 1'b0,
  parameter int CONV_HALF = sar_port_pkg::CONV_HALF_DEFAULT,
  parameter int FIFO_DEPTH = sar_port_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  sar_link_if.host link,
  input wire logic run_i,
  output logic idle_o,
  output logic sample_valid_o,
  input wire logic sample_ready_i,
  output logic [sar_port_pkg::RESULT_W-1:0] sample_o
);
  import sar_port_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SELECT = 3'b001,
    H_START = 3'b010,
    H_WAIT_BUSY = 3'b011,
    H_WAIT_DONE = 3'b100,
    H_READ_LO = 3'b101,
    H_READ_HI = 3'b110,
    H_PUSH = 3'b111
  } host_state_t;

  host_state_t state;
  logic [7:0] count;
  logic [RESULT_W-1:0] word;
  logic fifo_ready;
  logic [1:0] busy_s;
  logic [RESULT_W-1:0] bus_s1;
  logic [RESULT_W-1:0] bus_s2;
  logic conv_clk;
  logic [7:0] div;
  logic clk_run;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      busy_s <= 2'h0;
      bus_s1 <= RESULT_RESET;
      bus_s2 <= RESULT_RESET;
    end else if (ce_i) begin
      busy_s <= {busy_s[0], link.busy};
      bus_s1 <= link.result_bus;
      bus_s2 <= bus_s1;
    end
  end

  // ---------------------------------------------------------------
  // Conversion clock divider
  // ---------------------------------------------------------------
  // Gated mode saves power; the divider only runs around a conversion
  assign clk_run = !GATED_CLOCK ||
                   state == H_WAIT_BUSY || state == H_WAIT_DONE;

  // Half period fixed by parameter keeps the rate within limits
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      conv_clk <= 1'b0;
      div <= 8'h00;
    end else if (ce_i) begin
      if (!clk_run) begin
        conv_clk <= 1'b0;
        div <= 8'h00;
      end else if (div == 8'(CONV_HALF - 1)) begin
        conv_clk <= ~conv_clk;
        div <= 8'h00;
      end else begin
        div <= div + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= H_IDLE;
      count <= 8'h00;
      word <= RESULT_RESET;
    end else if (ce_i) begin
      case (state)
        H_IDLE: begin
          // Counts down the acquisition gap left from the last read
          if (count != 8'h00) begin
            count <= count - 8'h01;
          end else if (run_i && fifo_ready) begin
            state <= H_SELECT;
          end
        end
        H_SELECT: begin
          state <= H_START;
          count <= 8'(START_CYCLES - 1);
        end
        H_START: begin
          if (count == 8'h00) begin
            state <= H_WAIT_BUSY;
            count <= 8'(READ_WAIT_CYCLES);
          end else begin
            count <= count - 8'h01;
          end
        end
        H_WAIT_BUSY: begin
          if (busy_s[1]) begin
            state <= H_WAIT_DONE;
          end
        end
        H_WAIT_DONE: begin
          if (!busy_s[1]) begin
            state <= H_READ_LO;
            count <= 8'(READ_WAIT_CYCLES);
          end
        end
        H_READ_LO: begin
          if (count != 8'h00) begin
            count <= count - 8'h01;
          end else if (BYTE_MODE) begin
            word[HALF_W-1:0] <= bus_s2[HALF_W-1:0];
            state <= H_READ_HI;
            count <= 8'(READ_WAIT_CYCLES);
          end else begin
            word <= bus_s2;
            state <= H_PUSH;
          end
        end
        H_READ_HI: begin
          // Read strobe stays low while the upper half is fetched
          if (count != 8'h00) begin
            count <= count - 8'h01;
          end else begin
            word[RESULT_W-1:HALF_W] <= bus_s2[HALF_W-1:0];
            state <= H_PUSH;
          end
        end
        H_PUSH: begin
          if (fifo_ready) begin
            state <= H_IDLE;
            count <= 8'(ACQ_CYCLES);
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  assign link.conv_clk = conv_clk;
  assign link.cs_n = !(state == H_SELECT || state == H_START ||
                       state == H_READ_LO || state == H_READ_HI);
  assign link.conversion_start_n = state != H_START;
  assign link.rd_n = !(state == H_READ_LO || state == H_READ_HI);
  assign link.byte_sel = state == H_READ_HI;
  assign idle_o = state == H_IDLE;

  sample_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .in_valid_i(state == H_PUSH),
    .in_ready_o(fifo_ready),
    .in_data_i(word),
    .out_valid_o(sample_valid_o),
    .out_ready_i(sample_ready_i),
    .out_data_o(sample_o)
  );
endmodule

// ### testbench/sar_port_props.sv
// Concurrent checks on the converter link
`timescale 1ns/1ps
module sar_port_props (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic conv_clk,
  input wire logic conversion_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic byte_sel,
  input wire logic busy,
  input wire logic [15:0] result_bus_out,
  input wire logic result_bus_oe
);
  logic conv_q;
  logic [5:0] rises;

  // Raw conversion clock rises since the last start strobe
  always_ff @(posedge clk_i) begin
    conv_q <= conv_clk;
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !conversion_start_n) begin
      rises <= 6'h00;
    end else if (conv_clk && !conv_q && rises != 6'h3F) begin
      rises <= rises + 6'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Windows of five cover the pin synchronizer latency
  bus_enable_a: assert property (
    (!rd_n && !cs_n) [*5] |-> result_bus_oe) else $error("bus not driven");
  bus_release_a: assert property (
    (rd_n || cs_n) [*5] |-> !result_bus_oe) else $error("bus not released");
  upper_half_a: assert property ($rose(byte_sel) && !rd_n |->
    ##5 result_bus_out[7:0] == $past(result_bus_out[15:8], 5))
    else $error("upper half not moved down");
  high_zero_a: assert property (
    byte_sel [*5] ##0 result_bus_oe |-> result_bus_out[15:8] == 8'h00)
    else $error("upper lines not zero");
  busy_rise_a: assert property (
    $fell(conversion_start_n) && !cs_n && !busy |-> ##[1:3] busy)
    else $error("busy late");
  busy_count_a: assert property (
    $fell(busy) |-> rises inside {[16:17]}) else $error("edge count wrong");
  busy_stays_a: assert property (
    busy && rises < 6'h0F |=> busy) else $error("busy dropped early");
  data_stable_a: assert property (
    (!busy && $stable(byte_sel) && result_bus_oe) [*5]
    |-> $stable(result_bus_out)) else $error("result moved");
  acq_gap_a: assert property (
    $fell(busy) |-> conversion_start_n [*4]) else $error("start too soon");
  // Slowest legal clock: a level may last at most 200 cycles
  clk_rate_a: assert property (
    busy && $changed(conv_clk) |-> ##[1:200] $changed(conv_clk))
    else $error("conversion clock too slow");
endmodule

// ### testbench/tb.sv
// Self-checking bench: host and converter joined, plus a bare converter
`timescale 1ns/1ps
module tb;
  import sar_port_pkg::*;
  localparam int DEPTH = 8;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic run_i = 1'b0;
  logic sample_ready_i = 1'b0;
  logic [15:0] analog_i = 16'h0000;
  logic [15:0] analog2_i = 16'h0000;
  logic idle_o;
  logic sample_valid_o;
  logic [15:0] sample_o;
  logic [15:0] last_result_o;
  int mismatches = 0;
  int checks = 0;
  int n;
  sar_link_if link1();
  sar_link_if link2();
  logic run3_i = 1'b0;
  logic ready3_i = 1'b0;
  logic valid3_o;
  logic [15:0] sample3_o;
  sar_link_if link3();

  sar_device sar_device_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .link(link1.device), .analog_sample_i(analog_i),
    .last_result_o(last_result_o));
  sar_device sar_device2_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .link(link2.device), .analog_sample_i(analog2_i), .last_result_o());
  sar_host #(.BYTE_MODE(1'b1), .GATED_CLOCK(1'b1), .FIFO_DEPTH(DEPTH))
    sar_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .link(link1.host), .run_i(run_i), .idle_o(idle_o),
    .sample_valid_o(sample_valid_o), .sample_ready_i(sample_ready_i),
    .sample_o(sample_o));
  // Second pair: full-width reads, free-running conversion clock
  sar_device sar_device3_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .link(link3.device), .analog_sample_i(analog2_i), .last_result_o());
  sar_host sar_host2_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .link(link3.host), .run_i(run3_i), .idle_o(),
    .sample_valid_o(valid3_o), .sample_ready_i(ready3_i),
    .sample_o(sample3_o));
  sar_port_props sar_port_props_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .conv_clk(link1.conv_clk), .conversion_start_n(link1.conversion_start_n),
    .cs_n(link1.cs_n), .rd_n(link1.rd_n), .byte_sel(link1.byte_sel),
    .busy(link1.busy), .result_bus_out(link1.result_bus_out),
    .result_bus_oe(link1.result_bus_oe));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wait_valid();
    for (int i = 0; i < 400 && sample_valid_o !== 1'b1; i++) step(1);
  endtask
  task automatic pop_all(input logic [15:0] exp, output int cnt);
    cnt = 0;
    sample_ready_i = 1'b1;
    while (sample_valid_o === 1'b1 && cnt < 20) begin
      check_word(sample_o, exp);
      cnt++;
      step(1);
    end
    sample_ready_i = 1'b0;
  endtask
  task automatic bare_start(input logic cs);
    link2.cs_n = cs;
    step(1);
    link2.conversion_start_n = 1'b0;
    step(1);
    link2.conversion_start_n = 1'b1;
    step(4);
  endtask
  task automatic conv_tick(input int k);
    repeat (k) begin
      link2.conv_clk = 1'b1;
      step(2);
      link2.conv_clk = 1'b0;
      step(2);
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_codes();
    logic [15:0] codes [5] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000,
      16'hA55A};
    foreach (codes[k]) begin
      analog_i = codes[k];
      run_i = 1'b1;
      wait_valid();
      run_i = 1'b0;
      step(200);
      pop_all(codes[k], n);
      check_bit(n == 1, 1'b1);
    end
  endtask
  task automatic t_capture();
    analog_i = 16'h3C96;
    run_i = 1'b1;
    for (int i = 0; i < 50 && link1.busy !== 1'b1; i++) step(1);
    analog_i = 16'h5A01;
    wait_valid();
    run_i = 1'b0;
    step(200);
    pop_all(16'h3C96, n);
    analog_i = 16'h0001;
    step(50);
    check_word(last_result_o, 16'h3C96);
  endtask
  // Far side stalls; the host must stop at a full buffer
  task automatic t_fifo_full();
    analog_i = 16'h1234;
    run_i = 1'b1;
    step(1500);
    check_bit(sample_valid_o, 1'b1);
    run_i = 1'b0;
    step(200);
    pop_all(16'h1234, n);
    check_bit(n == DEPTH, 1'b1);
    check_bit(idle_o, 1'b1);
  endtask
  task automatic t_bare();
    analog2_i = 16'hC3A5;
    bare_start(1'b1);
    conv_tick(2);
    check_bit(link2.busy, 1'b0);
    bare_start(1'b0);
    check_bit(link2.busy, 1'b1);
    analog2_i = 16'h0F0F;
    conv_tick(15);
    check_bit(link2.busy, 1'b1);
    conv_tick(1);
    step(4);
    check_bit(link2.busy, 1'b0);
    link2.rd_n = 1'b0;
    step(5);
    check_word(link2.result_bus, 16'hC3A5);
    link2.byte_sel = 1'b1;
    step(5);
    check_word(link2.result_bus, 16'h00C3);
    link2.rd_n = 1'b1;
    step(5);
    check_bit(link2.result_bus_oe, 1'b0);
    link2.cs_n = 1'b1;
    link2.rd_n = 1'b0;
    step(5);
    check_bit(link2.result_bus_oe, 1'b0);
    link2.rd_n = 1'b1;
  endtask
  task automatic t_word();
    analog2_i = 16'h9E37;
    run3_i = 1'b1;
    for (int i = 0; i < 400 && valid3_o !== 1'b1; i++) step(1);
    run3_i = 1'b0;
    check_bit(valid3_o, 1'b1);
    check_word(sample3_o, 16'h9E37);
    ready3_i = 1'b1;
    step(1);
    ready3_i = 1'b0;
    check_bit(valid3_o, 1'b0);
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    link2.conv_clk = 1'b0;
    link2.conversion_start_n = 1'b1;
    link2.cs_n = 1'b1;
    link2.rd_n = 1'b1;
    link2.byte_sel = 1'b0;
    step(6);
    nrst_i = 1'b1;
    t_codes();
    t_capture();
    t_fifo_full();
    t_bare();
    t_word();
    print_verdict();
  end

  // Whole run needs about 4000 cycles
  initial begin
    step(20000);
    mismatches++;
    print_verdict();
  end
endmodule
